// ==== motion_status_irq_flags_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module motion_status_irq_flags_bench;
	import msirq_pkg::*;
	// ========================================================
	// signals
	typedef struct packed {
		logic [7:0] mc;
		logic [4:0] det;
		logic [2:0] fifo;
		logic [7:0] exp;
	} msirq_row_t;
	logic pclk, presetn, sample_written_i, active_mode_i;
	logic psel, penable, pwrite, pready, pslverr, irq_o, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [7:0] v;
	msirq_motion_t det_i;
	msirq_fifo_t fifo_i;
	int num_errors = 0;
	int n_compared = 0;
	// live flag expectations: feature gating and queue or
	msirq_row_t rows [8] = '{'{8'h00, 5'h1F, 3'h0, 8'h00},
		'{8'h01, 5'h1F, 3'h0, 8'h03}, '{8'h1D, 5'h1F, 3'h0, 8'h1F},
		'{8'h04, 5'h1F, 3'h0, 8'h04}, '{8'h18, 5'h0A, 3'h0, 8'h08},
		'{8'h1D, 5'h15, 3'h1, 8'h35}, '{8'h00, 5'h00, 3'h2, 8'h20},
		'{8'h00, 5'h00, 3'h4, 8'h20}};
	// ========================================================
	// design and host
	msirq_flags #(.ADDR_W(12)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .det_i(det_i), .fifo_i(fifo_i),
		.sample_written_i(sample_written_i),
		.active_mode_i(active_mode_i), .irq_o(irq_o));
	msirq_host host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	// ========================================================
	// tasks
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] idx,
		input logic [7:0] d);
		host.xfer(w, idx, d, v, e);
		if (host.hung != 0)
		begin
			num_errors++;
			summarize();
		end
	endtask : acc
	// one-cycle sample pulse, then a cycle for the flag to land
	task automatic pulse();
		@(posedge pclk);
		sample_written_i <= 1'b1;
		@(posedge pclk);
		sample_written_i <= 1'b0;
		@(posedge pclk);
	endtask : pulse
	// ========================================================
	// clock
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// ========================================================
	// main sequence
	initial
	begin
		presetn = 1'b0;
		det_i = '0;
		fifo_i = '0;
		sample_written_i = 1'b0;
		active_mode_i = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		acc(1'b0, IDX_LIVE, 8'h00);
		chk("live reset", 8'h00, v);
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("pending reset", 8'h00, v);
		acc(1'b0, 8'h20, 8'h00);
		chk("unmapped error", 8'h01, {7'h00, e});
		foreach (rows[i])
		begin
			acc(1'b1, IDX_MOTION_CTRL, rows[i].mc);
			@(posedge pclk);
			det_i <= rows[i].det;
			fifo_i <= rows[i].fifo;
			acc(1'b0, IDX_LIVE, 8'h00);
			chk("live row", rows[i].exp, v);
		end
		// nothing may pend while every source enable is off
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("pending gated", 8'h00, v);
		det_i <= '0;
		fifo_i <= '0;
		// enables for tilt, movement, queue and sample only
		acc(1'b1, IDX_INT_EN, 8'hA5);
		acc(1'b1, IDX_FIFO_IRQ_EN, 8'h07);
		acc(1'b1, IDX_MOTION_CTRL, 8'h1D);
		acc(1'b1, IDX_IRQ_MASK, 8'hBF);
		active_mode_i <= 1'b1;
		det_i <= 5'h1F;
		fifo_i <= 3'h4;
		pulse();
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("pending set", 8'hA5, v);
		chk("irq raised", 8'h01, {7'h00, irq_o});
		acc(1'b0, IDX_LIVE, 8'h00);
		chk("live new sample", 8'hBF, v);
		acc(1'b0, IDX_LIVE, 8'h00);
		chk("live after read", 8'h3F, v);
		acc(1'b1, IDX_PENDING, 8'h00);
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("clear all", 8'h00, v);
		acc(1'b0, IDX_IRQ_EVENTS, 8'h00);
		chk("events", 8'hA5, v);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 8'h00, {7'h00, irq_o});
		// masked events must not raise the line
		acc(1'b1, IDX_IRQ_MASK, 8'h00);
		acc(1'b1, IDX_COMM_CTRL, 8'h01);
		det_i <= '0;
		@(posedge pclk);
		det_i <= 5'h1F;
		repeat (2) @(posedge pclk);
		chk("irq masked", 8'h00, {7'h00, irq_o});
		acc(1'b1, IDX_PENDING, 8'h01);
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("selective clear", 8'h04, v);
		// only individually enabled queue conditions may pend
		fifo_i <= '0;
		acc(1'b1, IDX_FIFO_IRQ_EN, 8'h03);
		fifo_i <= 3'h4;
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("queue gated", 8'h04, v);
		fifo_i <= 3'h1;
		acc(1'b0, IDX_PENDING, 8'h00);
		chk("queue empty pend", 8'h24, v);
		active_mode_i <= 1'b0;
		pulse();
		acc(1'b0, IDX_LIVE, 8'h00);
		chk("live standby", 8'h3F, v);
		summarize();
	end
endmodule : motion_status_irq_flags_bench
`default_nettype wire

// ==== msirq_flags.sv ====
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module msirq_flags #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// detector and sampler side, same clock
	input wire msirq_pkg::msirq_motion_t det_i,
	input wire msirq_pkg::msirq_fifo_t fifo_i,
	input wire logic sample_written_i,
	input wire logic active_mode_i,
	// interrupt
	output logic irq_o
);
	import msirq_pkg::*;

	// ========================================================
	// elaboration check
	if (ADDR_W < 10)
	begin : g_bad_addr
		$error("ADDR_W too small for the register map");
	end

	// ========================================================
	// helpers
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] idx);
		reg_hit = (a == ADDR_W'({idx, BYTE_LANE_ZERO}));
	endfunction : reg_hit

	function automatic msirq_motion_t gate_motion(input msirq_motion_t d,
		input logic [7:0] mc);
		gate_motion.tilt = d.tilt & mc[MC_TILT];
		gate_motion.flip = d.flip & mc[MC_FLIP];
		gate_motion.movement = d.movement & mc[MC_MOVE];
		gate_motion.shake = d.shake & mc[MC_SHAKE];
		gate_motion.tilt35 = d.tilt35 & mc[MC_TILT35];
	endfunction : gate_motion

	// ========================================================
	// declarations
	logic [7:0] int_en_ff;
	logic [7:0] motion_ctrl_ff;
	logic [2:0] fifo_irq_en_ff;
	logic sel_clr_ff;
	logic [7:0] irq_mask_ff;
	logic [7:0] irq_evt_ff;
	logic [7:0] nxt_irq_evt;
	logic [7:0] pend_ff;
	logic [7:0] nxt_pend;
	logic new_sample_ff;
	logic nxt_new_sample;
	logic [4:0] motion_prev_ff;
	logic fifo_prev_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic setup;
	logic access;
	logic wr_acc;
	logic mapped;
	msirq_motion_t live_motion;
	logic [7:0] live_val;
	logic [7:0] rd_val;
	logic [4:0] motion_src;
	logic [4:0] motion_rise;
	logic fifo_src;
	logic fifo_rise;
	logic acq_set;
	logic [7:0] pend_set;
	logic [7:0] clr_mask;
	logic live_rd;
	logic evt_rd;
	logic pend_wr;
	logic sample_ok;

	// ========================================================
	// apb phases; zero wait states so pready is always high
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_acc = access & pwrite & pstrb[0];
	assign pready = 1'b1;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;

	// decoder for the whole map
	assign mapped = reg_hit(paddr, IDX_INT_EN)
		| reg_hit(paddr, IDX_MOTION_CTRL)
		| reg_hit(paddr, IDX_LIVE)
		| reg_hit(paddr, IDX_PENDING)
		| reg_hit(paddr, IDX_FIFO_IRQ_EN)
		| reg_hit(paddr, IDX_COMM_CTRL)
		| reg_hit(paddr, IDX_IRQ_EVENTS)
		| reg_hit(paddr, IDX_IRQ_MASK);

	// read side effects fire only at the completing access edge
	assign live_rd = access & ~pwrite & reg_hit(paddr, IDX_LIVE);
	assign evt_rd = access & ~pwrite & reg_hit(paddr, IDX_IRQ_EVENTS);
	assign pend_wr = wr_acc & reg_hit(paddr, IDX_PENDING);

	// ========================================================
	// live flags: motion bits are straight gated detector levels
	assign live_motion = gate_motion(det_i, motion_ctrl_ff);
	assign live_val = {new_sample_ff, 1'b0, |fifo_i, live_motion};

	// ========================================================
	// pending sources; motion and queue use edges so that a clear is not undone by a held level, sample uses the pulse itself
	assign motion_src = live_motion & int_en_ff[4:0];
	assign motion_rise = motion_src & ~motion_prev_ff;
	assign fifo_src = int_en_ff[POS_FIFO]
		& (|(fifo_i & fifo_irq_en_ff));
	assign fifo_rise = fifo_src & ~fifo_prev_ff;
	assign sample_ok = sample_written_i & active_mode_i;
	assign acq_set = sample_ok & int_en_ff[POS_NEW];
	assign pend_set = {acq_set, 1'b0, fifo_rise, motion_rise};

	// clear all by default, or only the written ones in selective mode
	assign clr_mask = sel_clr_ff ? pwdata[7:0] : ALL_ONES;

	// set wins over a clear in the same cycle
	assign nxt_pend = ((pend_ff & ~(pend_wr ? clr_mask : RST_BYTE))
		| pend_set) & FLAG_MASK;

	// new sample: cleared by a live read, set wins, dead outside active
	assign nxt_new_sample = active_mode_i
		& ((new_sample_ff & ~live_rd) | sample_written_i);

	// events: a pending bit newly raised; read clears, set wins
	assign nxt_irq_evt = (irq_evt_ff & ~(evt_rd ? ALL_ONES : RST_BYTE))
		| pend_set;
	assign irq_o = |(irq_evt_ff & irq_mask_ff);

	// ========================================================
	// read mux, evaluated during the setup cycle
	always_comb
	begin
		rd_val = RST_BYTE;
		if (reg_hit(paddr, IDX_INT_EN))
			rd_val = int_en_ff;
		else if (reg_hit(paddr, IDX_MOTION_CTRL))
			rd_val = motion_ctrl_ff;
		else if (reg_hit(paddr, IDX_LIVE))
			rd_val = live_val;
		else if (reg_hit(paddr, IDX_PENDING))
			rd_val = pend_ff;
		else if (reg_hit(paddr, IDX_FIFO_IRQ_EN))
			rd_val = {5'h00, fifo_irq_en_ff};
		else if (reg_hit(paddr, IDX_COMM_CTRL))
			rd_val = {7'h00, sel_clr_ff};
		else if (reg_hit(paddr, IDX_IRQ_EVENTS))
			rd_val = irq_evt_ff;
		else if (reg_hit(paddr, IDX_IRQ_MASK))
			rd_val = irq_mask_ff;
	end

	// ========================================================
	// read data and error latched at setup, held through access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= RST_WORD;
			pslverr_ff <= 1'b0;
		end
		else if (setup)
		begin
			prdata_ff <= {24'h00_0000, rd_val};
			pslverr_ff <= ~mapped;
		end
	end

	// ========================================================
	// software control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_en_ff <= RST_BYTE;
			motion_ctrl_ff <= RST_BYTE;
			fifo_irq_en_ff <= RST_FIFO_EN;
			sel_clr_ff <= 1'b0;
			irq_mask_ff <= RST_BYTE;
		end
		else if (wr_acc)
		begin
			if (reg_hit(paddr, IDX_INT_EN))
				int_en_ff <= pwdata[7:0] & FLAG_MASK;
			if (reg_hit(paddr, IDX_MOTION_CTRL))
				motion_ctrl_ff <= pwdata[7:0];
			if (reg_hit(paddr, IDX_FIFO_IRQ_EN))
				fifo_irq_en_ff <= pwdata[2:0];
			if (reg_hit(paddr, IDX_COMM_CTRL))
				sel_clr_ff <= pwdata[CC_SEL_CLR];
			if (reg_hit(paddr, IDX_IRQ_MASK))
				irq_mask_ff <= pwdata[7:0] & FLAG_MASK;
		end
	end

	// ========================================================
	// flag state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_ff <= RST_BYTE;
			new_sample_ff <= 1'b0;
			irq_evt_ff <= RST_BYTE;
		end
		else
		begin
			pend_ff <= nxt_pend;
			new_sample_ff <= nxt_new_sample;
			irq_evt_ff <= nxt_irq_evt;
		end
	end

	// edge history of the enabled sources
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			motion_prev_ff <= 5'h00;
			fifo_prev_ff <= 1'b0;
		end
		else
		begin
			motion_prev_ff <= motion_src;
			fifo_prev_ff <= fifo_src;
		end
	end

	// ========================================================
	// checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_LIVE_RESV: assert property (
		setup && !pwrite && reg_hit(paddr, IDX_LIVE)
		|=> prdata[31:8] == 24'h00_0000 && !prdata[POS_RESV])
		else $error("live register reserved bits not zero");

	AST_TILT_GATE: assert property (
		!motion_ctrl_ff[MC_TILT] |-> !live_val[0])
		else $error("tilt live bit set while feature off");

	AST_FLIP_GATE: assert property (
		det_i.flip && !motion_ctrl_ff[MC_FLIP] |-> !live_val[1])
		else $error("flip live bit set while feature off");

	// each feature checked on its own, not only when all three are off
	AST_MOTION_GATE: assert property (
		!(|(live_val[4:2] & ~{motion_ctrl_ff[MC_TILT35],
		motion_ctrl_ff[MC_SHAKE], motion_ctrl_ff[MC_MOVE]})))
		else $error("motion live bits set while features off");

	AST_LIVE_FOLLOW: assert property (
		setup && !pwrite && reg_hit(paddr, IDX_LIVE)
		|=> prdata[4:0] == $past(det_i & motion_ctrl_ff[4:0]
		& 5'h1D | {4'h0, det_i.flip & motion_ctrl_ff[MC_FLIP]} << 1))
		else $error("live motion bits do not follow detectors");

	AST_FIFO_OR: assert property (
		setup && !pwrite && reg_hit(paddr, IDX_LIVE)
		|=> prdata[POS_FIFO] == $past(|fifo_i))
		else $error("live queue bit is not the OR of flags");

	AST_NEW_SET: assert property (
		sample_written_i && active_mode_i |=> new_sample_ff)
		else $error("new sample not flagged");

	AST_NEW_INACTIVE: assert property (
		!active_mode_i |=> !new_sample_ff)
		else $error("new sample flagged outside active mode");

	AST_NEW_CLR: assert property (
		live_rd && !sample_written_i |=> !new_sample_ff [*1])
		else $error("live read did not clear new sample");

	AST_PEND_GATE: assert property (
		$rose(pend_ff[0]) |-> $past(int_en_ff[0] && motion_ctrl_ff[MC_TILT]))
		else $error("tilt pending without enables");

	AST_CLR_ALL: assert property (
		pend_wr && !sel_clr_ff && pend_set == RST_BYTE
		|=> pend_ff == RST_BYTE)
		else $error("write did not clear all pending bits");

	AST_CLR_SEL: assert property (
		pend_wr && sel_clr_ff && pend_set == RST_BYTE
		|=> pend_ff == ($past(pend_ff) & ~$past(pwdata[7:0])))
		else $error("selective clear changed wrong bits");

	// unselected bits survive even when a source sets in the same cycle
	AST_SEL_KEEP: assert property (
		pend_wr && sel_clr_ff
		|=> (pend_ff & $past(pend_ff & ~pwdata[7:0]))
		== $past(pend_ff & ~pwdata[7:0]))
		else $error("selective clear dropped an unselected bit");

	AST_PEND_RESV: assert property (
		!pend_ff[POS_RESV])
		else $error("pending reserved bit set");

	AST_FIFO_PEND: assert property (
		fifo_rise |=> pend_ff[POS_FIFO] ##0 $past(int_en_ff[POS_FIFO]))
		else $error("queue pending not raised");

	AST_ACQ: assert property (
		acq_set |=> pend_ff[POS_NEW] && irq_evt_ff[POS_NEW])
		else $error("sample pending not raised");

	COV_SEL_CLR: cover property (pend_wr && sel_clr_ff && pend_ff != 8'h00);
	COV_ALL_CLR: cover property (pend_wr && !sel_clr_ff && pend_ff != 8'h00);
	COV_IRQ: cover property (!irq_o ##1 irq_o);
	COV_NEW_READ: cover property (new_sample_ff && live_rd);
endmodule : msirq_flags
`default_nettype wire

// ==== msirq_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// host model: apb master issuing single transfers
module msirq_host (
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	int hung = 0;
	// idle bus from time zero so the slave sees no stray request
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end
	// one transfer; the wait for pready is bounded so a dead slave shows
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {24'h00_0000, wd};
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
			hung++;
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : msirq_host
`default_nettype wire

// ==== msirq_pkg.sv ====
`default_nettype none
package msirq_pkg;
	// ========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0] IDX_INT_EN = 8'h06;
	localparam logic [7:0] IDX_MOTION_CTRL = 8'h09;
	localparam logic [7:0] IDX_LIVE = 8'h13;
	localparam logic [7:0] IDX_PENDING = 8'h14;
	localparam logic [7:0] IDX_FIFO_IRQ_EN = 8'h2E;
	localparam logic [7:0] IDX_COMM_CTRL = 8'h31;
	localparam logic [7:0] IDX_IRQ_EVENTS = 8'h40;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
	localparam logic [1:0] BYTE_LANE_ZERO = 2'h0;

	// ========================================================
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_FIFO_EN = 3'h0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	// ========================================================
	// flag layout shared by live, pending, event and mask registers
	localparam int POS_FIFO = 5;
	localparam int POS_RESV = 6;
	localparam int POS_NEW = 7;
	localparam logic [7:0] FLAG_MASK = 8'hBF;
	localparam logic [7:0] ALL_ONES = 8'hFF;

	// motion control enable positions
	localparam int MC_TILT = 0;
	localparam int MC_FLIP = 0;
	localparam int MC_MOVE = 2;
	localparam int MC_SHAKE = 3;
	localparam int MC_TILT35 = 4;

	// communications control
	localparam int CC_SEL_CLR = 0;

	// ========================================================
	// carriers: detector conditions and queue flags
	typedef struct packed {
		logic tilt35;
		logic shake;
		logic movement;
		logic flip;
		logic tilt;
	} msirq_motion_t;

	typedef struct packed {
		logic queue_level_reached;
		logic full;
		logic empty;
	} msirq_fifo_t;
endpackage : msirq_pkg
`default_nettype wire
